// *** analog_ref_regulator_control.sv ***
// Top: AXI4-Lite register bank for fixed reference, temperature indicator and regulator mode
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`default_nettype none
module analog_ref_regulator_control
	import ref_reg_pkg::*;
#(
	parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Device conditions
	input  wire regulator_conditions_t conditions,
	// Analog controls and status
	output analog_controls_t           analog_ctrl,
	output reg_power_mode_t            regulator_mode,
	output logic                       irq
);
	// ==========================================================
	// Storage
	logic [7:0]            ref_ctrl_reg;
	logic [7:0]            reg_ctrl_reg;
	logic [NUM_EVENTS-1:0] irq_status_reg;
	logic [NUM_EVENTS-1:0] irq_mask_reg;
	logic                  aw_held_reg;
	logic                  w_held_reg;
	logic [ADDR_W-1:0]     awaddr_reg;
	logic [31:0]           wdata_reg;
	logic                  wstrb0_reg;
	logic                  ready_prev_reg;
	logic                  track_prev_reg;
	logic                  ref_ready;
	reg_power_mode_t       mode_now;
	reg_power_mode_t       mode_reg;
	logic                  wr_fire;
	logic                  wr_hit;
	logic                  wr_lane0;
	logic                  wr_ref_ctrl;
	logic                  wr_reg_ctrl;
	logic                  wr_status;
	logic                  wr_mask;
	logic                  rd_fire;
	logic [31:0]           rd_value;
	logic                  rd_hit;
	logic [NUM_EVENTS-1:0] events;
	logic [NUM_EVENTS-1:0] clear_bits;

	// ==========================================================
	// Submodules
	// Settle count is a parameter so a bench may shorten the delay
	ref_settle_timer #(
		.SETTLE_COUNT (SETTLE_COUNT)
	) u_settle (
		.mclk   (mclk),
		.rstn   (rstn),
		.enable (ref_ctrl_reg[BIT_REF_ENABLE]),
		.ready  (ref_ready)
	);

	regulator_mode_select u_mode (
		.sleep_mode_select (reg_ctrl_reg[BIT_SLEEP_MODE]),
		.cond              (conditions),
		.mode              (mode_now)
	);

	// ==========================================================
	// Write channel: address and data accepted in either order
	// Nothing is taken while a response waits, so one write at most is under way
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign wr_fire       = aw_held_reg && w_held_reg && !s_axi_bvalid;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			aw_held_reg <= 1'b0;
			awaddr_reg  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_reg <= 1'b1;
			awaddr_reg  <= s_axi_awaddr;
		end else if (wr_fire) begin
			aw_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			w_held_reg <= 1'b0;
			wdata_reg  <= '0;
			wstrb0_reg <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_reg <= 1'b1;
			wdata_reg  <= s_axi_wdata;
			wstrb0_reg <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_held_reg <= 1'b0;
		end
	end

	// Write decode: one strobe per writable register
	always_comb begin
		wr_hit      = 1'b1;
		wr_ref_ctrl = 1'b0;
		wr_reg_ctrl = 1'b0;
		wr_status   = 1'b0;
		wr_mask     = 1'b0;
		if (awaddr_reg == ADDR_REF_CTRL) begin
			wr_ref_ctrl = 1'b1;
		end else if (awaddr_reg == ADDR_REG_CTRL) begin
			wr_reg_ctrl = 1'b1;
		end else if (awaddr_reg == ADDR_IRQ_STATUS) begin
			wr_status = 1'b1;
		end else if (awaddr_reg == ADDR_IRQ_MASK) begin
			wr_mask = 1'b1;
		end else if (awaddr_reg == ADDR_CONDITIONS) begin
			// Read-only mode view: the write is answered, nothing is stored
			wr_hit = 1'b1;
		end else begin
			wr_hit = 1'b0;
		end
	end

	// Only byte lane 0 carries register bits; a write without it is answered but ignored
	assign wr_lane0 = wr_fire && wstrb0_reg;

	// Unmapped addresses earn an error response and change nothing
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Control registers; only byte lane 0 carries data
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ref_ctrl_reg <= REF_CTRL_RESET;
		end else if (wr_lane0 && wr_ref_ctrl) begin
			// Ready bit and bits 3-2 are not stored
			ref_ctrl_reg <= wdata_reg[7:0] & REF_CTRL_WMASK;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_ctrl_reg <= REG_CTRL_RESET;
		end else if (wr_lane0 && wr_reg_ctrl) begin
			// Reserved bit stays writable; software is expected to keep it set
			reg_ctrl_reg <= wdata_reg[7:0] & REG_CTRL_WMASK;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_mask_reg <= '0;
		end else if (wr_lane0 && wr_mask) begin
			irq_mask_reg <= wdata_reg[NUM_EVENTS-1:0];
		end
	end

	// ==========================================================
	// Events: ready edges and entry to tracking
	// Ready history starts low, as ready itself does out of reset, so no false edge follows reset
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ready_prev_reg <= 1'b0;
		end else begin
			ready_prev_reg <= ref_ready;
		end
	end

	// A supply already low at release counts as an entry to tracking and is reported
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			track_prev_reg <= 1'b0;
		end else begin
			track_prev_reg <= (mode_now == PM_TRACKING);
		end
	end

	assign events[EV_READY_RISE] = ref_ready && !ready_prev_reg;
	assign events[EV_READY_FALL] = !ref_ready && ready_prev_reg;
	assign events[EV_TRACKING]   = (mode_now == PM_TRACKING) && !track_prev_reg;

	// ==========================================================
	// Interrupt status: sticky, write one to clear
	assign clear_bits = (wr_lane0 && wr_status) ? wdata_reg[NUM_EVENTS-1:0] : '0;

	// Set is tested first, so an event in the clearing cycle is never lost
	for (genvar e = 0; e < NUM_EVENTS; e++) begin : g_status
		always_ff @(posedge mclk or negedge rstn) begin
			if (!rstn) begin
				irq_status_reg[e] <= 1'b0;
			end else if (events[e]) begin
				irq_status_reg[e] <= 1'b1;
			end else if (clear_bits[e]) begin
				irq_status_reg[e] <= 1'b0;
			end
		end
	end

	assign irq = |(irq_status_reg & irq_mask_reg);

	// ==========================================================
	// Read channel
	always_comb begin
		rd_value = '0;
		rd_hit   = 1'b1;
		if (s_axi_araddr == ADDR_REF_CTRL) begin
			rd_value[7:0] = ref_ctrl_reg;
			rd_value[BIT_REF_READY] = ref_ready;
		end else if (s_axi_araddr == ADDR_REG_CTRL) begin
			rd_value[7:0] = reg_ctrl_reg;
		end else if (s_axi_araddr == ADDR_IRQ_STATUS) begin
			rd_value[NUM_EVENTS-1:0] = irq_status_reg;
		end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
			rd_value[NUM_EVENTS-1:0] = irq_mask_reg;
		end else if (s_axi_araddr == ADDR_CONDITIONS) begin
			rd_value[1:0] = mode_reg;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// A new read address waits until the answer has been taken
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_value;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Analog outputs come straight from control flops
	always_comb begin
		analog_ctrl.fixed_reference_enable = ref_ctrl_reg[BIT_REF_ENABLE];
		analog_ctrl.adc_ref_gain_select    = adc_ref_gain_t'(ref_ctrl_reg[BIT_GAIN_HI:BIT_GAIN_LO]);
		analog_ctrl.temp_sense_enable      = ref_ctrl_reg[BIT_TEMP_EN];
		analog_ctrl.temp_range_select      = ref_ctrl_reg[BIT_TEMP_RANGE];
	end

	// ==========================================================
	// Regulator mode is held in a flop so the analog side never sees a decode glitch
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			// Full-power regulation until the first conditions are sampled
			mode_reg <= PM_HIGH;
		end else begin
			mode_reg <= mode_now;
		end
	end

	assign regulator_mode = mode_reg;
endmodule : analog_ref_regulator_control
`default_nettype wire

// *** analog_ref_regulator_control_assertions.sv ***
// Checker: port-level assertions for the reference and regulator control block
`default_nettype none
module analog_ref_regulator_control_assertions
	import ref_reg_pkg::*;
(
	input wire logic                  mclk,
	input wire logic                  rstn,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire regulator_conditions_t conditions,
	input wire analog_controls_t      analog_ctrl,
	input wire reg_power_mode_t       regulator_mode,
	input wire logic                  irq
);
	// ==========================================================
	// Regulator mode, register side effects and response handshakes
	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	logic awake;
	logic dozing;
	assign awake  = !conditions.supply_low && !conditions.in_sleep;
	assign dozing = !conditions.supply_low && conditions.in_sleep;
	track_mode_a: assert property (conditions.supply_low |=> regulator_mode == PM_TRACKING)
		else $error("tracking not selected on low supply");
	awake_high_a: assert property (awake && conditions.clock_source != OSC_LF_31K_500K |=> regulator_mode == PM_HIGH)
		else $error("awake fast clock not high power");
	awake_low_a: assert property (awake && conditions.clock_source == OSC_LF_31K_500K |=> regulator_mode == PM_LOW)
		else $error("awake slow clock not low power");
	sleep_force_a: assert property (dozing && (|conditions[6:1]) |=> regulator_mode == PM_LOW)
		else $error("busy sleep not forced low");
	sleep_mode_a: assert property (dozing |=> regulator_mode inside {PM_LOW, PM_POWER_SAVE})
		else $error("sleep mode neither low nor power save");
	ctrl_by_write_a: assert property ($changed(analog_ctrl) |-> $rose(s_axi_bvalid))
		else $error("analog controls moved without a write");
	irq_clear_a: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
		else $error("interrupt dropped without a write");
	bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response repeated");
	rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read response repeated");
endmodule : analog_ref_regulator_control_assertions

bind analog_ref_regulator_control analog_ref_regulator_control_assertions u_chk (
	.mclk(mclk), .rstn(rstn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .conditions(conditions),
	.analog_ctrl(analog_ctrl), .regulator_mode(regulator_mode), .irq(irq));
`default_nettype wire

// *** ref_reg_pkg.sv ***
// Package: register map, field layout, reset values and modes for the reference/regulator control block
`default_nettype none
package ref_reg_pkg;
	// ==========================================================
	// Register map
	localparam logic [11:0] ADDR_REF_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_REG_CTRL   = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK   = 12'h00c;
	localparam logic [11:0] ADDR_CONDITIONS = 12'h010;
	localparam int          ADDR_W          = 12;

	// ==========================================================
	// Fields
	localparam int BIT_REF_ENABLE  = 7;
	localparam int BIT_REF_READY   = 6;
	localparam int BIT_TEMP_EN     = 5;
	localparam int BIT_TEMP_RANGE  = 4;
	localparam int BIT_GAIN_HI     = 1;
	localparam int BIT_GAIN_LO     = 0;
	localparam int BIT_SLEEP_MODE  = 1;
	localparam int BIT_RESERVED    = 0;

	localparam logic [7:0] REF_CTRL_WMASK  = 8'hb3;
	localparam logic [7:0] REG_CTRL_WMASK  = 8'h03;
	localparam logic [7:0] REF_CTRL_RESET  = 8'h00;
	localparam logic [7:0] REG_CTRL_RESET  = 8'h01;

	// Status / mask layout
	localparam int         NUM_EVENTS      = 3;
	localparam int         EV_READY_RISE   = 0;
	localparam int         EV_READY_FALL   = 1;
	localparam int         EV_TRACKING     = 2;

	// Settling delay of the reference
	localparam int         SETTLE_NS       = 25000;
	localparam int         CLK_PERIOD_NS   = 10;
	localparam int         SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// AXI responses
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		GAIN_OFF,
		GAIN_1X,
		GAIN_2X,
		GAIN_4X
	} adc_ref_gain_t;

	typedef enum logic [1:0] {
		PM_HIGH,
		PM_LOW,
		PM_POWER_SAVE,
		PM_TRACKING
	} reg_power_mode_t;

	typedef enum logic [1:0] {
		OSC_EXTERNAL,
		OSC_HF_16M,
		OSC_MF_1M_8M,
		OSC_LF_31K_500K
	} clock_source_t;

	// Operating conditions that steer the regulator mode
	typedef struct packed {
		logic          in_sleep;
		clock_source_t clock_source;
		logic          high_freq_internal_osc_active;
		logic          peripherals_active;
		logic          brownout_reset_enabled;
		logic          hf_osc_serves_peripheral;
		logic          self_write_active;
		logic          adc_converting;
		logic          supply_low;
	} regulator_conditions_t;

	// Analog control outputs
	typedef struct packed {
		logic          fixed_reference_enable;
		adc_ref_gain_t adc_ref_gain_select;
		logic          temp_sense_enable;
		logic          temp_range_select;
	} analog_controls_t;
endpackage : ref_reg_pkg
`default_nettype wire

// *** ref_settle_timer.sv ***
// Settling timer: raises ready once the enabled reference has been on for the settle count
`default_nettype none
module ref_settle_timer
	import ref_reg_pkg::*;
#(
	parameter int SETTLE_COUNT = SETTLE_CYCLES
) (
	input  wire logic mclk,
	input  wire logic rstn,
	input  wire logic enable,
	output logic      ready
);
	localparam int CW = $clog2(SETTLE_COUNT + 1);
	localparam logic [CW-1:0] LAST = CW'(SETTLE_COUNT);

	logic [CW-1:0] count_reg;

	// ==========================================================
	// Counter restarts whenever the enable drops
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= '0;
		end else if (!enable) begin
			count_reg <= '0;
		end else if (count_reg != LAST) begin
			count_reg <= count_reg + CW'(1);
		end
	end

	// Ready only while enabled and settled; low at once on disable
	assign ready = enable && (count_reg == LAST);
endmodule : ref_settle_timer
`default_nettype wire

// *** regulator_mode_select.sv ***
// Regulator power-mode selector from sleep state, clock source and activity
`default_nettype none
module regulator_mode_select
	import ref_reg_pkg::*;
(
	input  wire logic                  sleep_mode_select,
	input  wire regulator_conditions_t cond,
	output reg_power_mode_t            mode
);
	logic force_low;

	// ==========================================================
	// Power-save is vetoed by any of these activities
	assign force_low = cond.brownout_reset_enabled || cond.hf_osc_serves_peripheral ||
		cond.self_write_active || cond.adc_converting;

	always_comb begin
		mode = PM_LOW;
		if (cond.supply_low) begin
			mode = PM_TRACKING;
		end else if (!cond.in_sleep) begin
			case (cond.clock_source)
				OSC_EXTERNAL, OSC_HF_16M, OSC_MF_1M_8M: mode = PM_HIGH;
				default: mode = PM_LOW;
			endcase
		end else if (!sleep_mode_select) begin
			mode = PM_LOW;
		end else if (!cond.high_freq_internal_osc_active && !cond.peripherals_active && !force_low) begin
			mode = PM_POWER_SAVE;
		end else begin
			mode = PM_LOW;
		end
	end
endmodule : regulator_mode_select
`default_nettype wire

// *** testbench.sv ***
// Testbench: register, settling, interrupt and regulator mode scenarios
`default_nettype none
module testbench
	import ref_reg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	localparam int         SC = 8;
	logic                  mclk = 0;
	logic                  rstn = 0;
	logic [ADDR_W-1:0]     awaddr = '0;
	logic [ADDR_W-1:0]     araddr = '0;
	logic                  awvalid = 0;
	logic                  wvalid = 0;
	logic                  arvalid = 0;
	logic                  awready, wready, arready, bvalid, rvalid, irq;
	logic [31:0]           wdata = '0;
	logic [3:0]            wstrb = 4'hf;
	logic [31:0]           rdata;
	logic [1:0]            bresp, rresp;
	regulator_conditions_t conditions = '0;
	analog_controls_t      analog_ctrl;
	reg_power_mode_t       regulator_mode;
	int                    num_errors = 0;
	int                    n_checks = 0;
	always #5 mclk = ~mclk;
	// Short settle count keeps the run brief
	analog_ref_regulator_control #(.SETTLE_COUNT(SC)) u_analog_ref_regulator_control (
		.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .conditions(conditions), .analog_ctrl(analog_ctrl),
		.regulator_mode(regulator_mode), .irq(irq));
	// ==========================================================
	// Shared tasks
	task automatic print_verdict;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(inout int n);
		n++;
		if (n > 100) begin
			num_errors++;
			print_verdict();
		end
	endtask : tick
	// Handshakes are sampled at the falling edge, which holds what the next rising edge sees
	task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
		logic ta, tw;
		logic bv = 0;
		int   n = 0;
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!bv) begin
			@(negedge mclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			bv = bvalid;
			r = bresp;
			@(posedge mclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			tick(n);
		end
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta;
		logic rv = 0;
		int   n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!rv) begin
			@(negedge mclk);
			ta = arvalid && arready;
			rv = rvalid;
			d = rdata;
			r = rresp;
			@(posedge mclk);
			if (ta) arvalid <= 1'b0;
			tick(n);
		end
	endtask : rd
	task automatic w(input logic [11:0] a, input logic [7:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk(r, RESP_OKAY);
	endtask : w
	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk({r, d}, {RESP_OKAY, exp});
	endtask : rc
	task automatic mc(input regulator_conditions_t c, input reg_power_mode_t m);
		conditions <= c;
		// Mode is registered: it follows the conditions one edge later
		@(posedge mclk);
		@(negedge mclk);
		chk(regulator_mode, m);
		@(posedge mclk);
		rc(ADDR_CONDITIONS, {30'h0, m});
	endtask : mc
	// ==========================================================
	// Scenarios
	task automatic t_fields;
		logic [1:0] g;
		for (int i = 0; i < 4; i++) begin
			g = i[1:0];
			w(ADDR_REF_CTRL, {3'b001, g[0], 2'b11, g});
			rc(ADDR_REF_CTRL, {24'h0, 3'b001, g[0], 2'b00, g});
			chk(analog_ctrl, {1'b0, g, 1'b1, g[0]});
		end
		// Indicator off before the bench ever raises the conversion flag, so no acquisition wait is owed
		w(ADDR_REF_CTRL, 8'h00);
		chk(analog_ctrl, 5'h00);
	endtask : t_fields
	task automatic t_ready;
		w(ADDR_REF_CTRL, 8'h80);
		rc(ADDR_REF_CTRL, 32'h80);
		repeat (SC + 2) @(posedge mclk);
		rc(ADDR_REF_CTRL, 32'hc0);
		chk(analog_ctrl.fixed_reference_enable, 1'b1);
		w(ADDR_REF_CTRL, 8'h00);
		rc(ADDR_REF_CTRL, 32'h00);
		w(ADDR_REF_CTRL, 8'h80);
		repeat (3) @(posedge mclk);
		w(ADDR_REF_CTRL, 8'h00);
		w(ADDR_REF_CTRL, 8'h80);
		repeat (SC - 4) @(posedge mclk);
		rc(ADDR_REF_CTRL, 32'h80);
		repeat (SC + 2) @(posedge mclk);
		rc(ADDR_REF_CTRL, 32'hc0);
		w(ADDR_REF_CTRL, 8'h00);
		rc(ADDR_IRQ_STATUS, 32'h3);
	endtask : t_ready
	task automatic t_irq;
		w(ADDR_IRQ_MASK, 8'h01);
		chk(irq, 1'b1);
		w(ADDR_IRQ_MASK, 8'h00);
		chk(irq, 1'b0);
		w(ADDR_IRQ_MASK, 8'h07);
		w(ADDR_IRQ_STATUS, 8'h01);
		chk(irq, 1'b1);
		rc(ADDR_IRQ_STATUS, 32'h2);
		w(ADDR_IRQ_STATUS, 8'h02);
		chk(irq, 1'b0);
		rc(ADDR_IRQ_STATUS, 32'h0);
	endtask : t_irq
	task automatic t_mode;
		w(ADDR_REG_CTRL, 8'hff);
		rc(ADDR_REG_CTRL, 32'h3);
		for (int i = 0; i < 4; i++) mc({1'b0, i[1:0], 7'h0}, i == 3 ? PM_LOW : PM_HIGH);
		w(ADDR_REG_CTRL, 8'h01);
		mc(10'h200, PM_LOW);
		w(ADDR_REG_CTRL, 8'h03);
		mc(10'h200, PM_POWER_SAVE);
		for (int k = 1; k < 7; k++) mc(10'h200 | (10'h1 << k), PM_LOW);
		mc(10'h201, PM_TRACKING);
		mc(10'h001, PM_TRACKING);
		rc(ADDR_IRQ_STATUS, 32'h4);
		chk(irq, 1'b1);
		w(ADDR_IRQ_STATUS, 8'h04);
		chk(irq, 1'b0);
	endtask : t_mode
	task automatic t_err;
		logic [31:0] d;
		logic [1:0]  r;
		rd(12'h100, d, r);
		chk(r, RESP_SLVERR);
		wr(12'h100, 8'hff, r);
		chk(r, RESP_SLVERR);
		wstrb <= 4'he;
		w(ADDR_REF_CTRL, 8'h20);
		wstrb <= 4'hf;
		rc(ADDR_REF_CTRL, 32'h0);
	endtask : t_err
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge mclk);
		rstn <= 1'b1;
		@(posedge mclk);
		rc(ADDR_REF_CTRL, 32'h0);
		rc(ADDR_REG_CTRL, 32'h1);
		rc(ADDR_IRQ_MASK, 32'h0);
		chk(irq, 1'b0);
		t_fields();
		t_ready();
		t_irq();
		t_mode();
		t_err();
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
